// ===== design/debug_coproc_pkg.sv
// constants and types for the debug coprocessor access check
package debug_coproc_pkg;

    // --------------------------------------------------------------
    // opcode_2 and register select codes
    // --------------------------------------------------------------
    localparam logic [2:0] OP2_BASE      = 3'h0;
    localparam logic [2:0] OP2_BRK_VALUE = 3'h4;
    localparam logic [2:0] OP2_BRK_CTRL  = 3'h5;
    localparam logic [2:0] OP2_WCH_VALUE = 3'h6;
    localparam logic [2:0] OP2_WCH_CTRL  = 3'h7;

    localparam logic [3:0] SEL_ID        = 4'h0;
    localparam logic [3:0] SEL_STATUS    = 4'h1;
    localparam logic [3:0] SEL_TRANSFER  = 4'h5;
    localparam logic [3:0] SEL_FAULT     = 4'h6;
    localparam logic [3:0] SEL_VECTOR    = 4'h7;
    localparam logic [3:0] SEL_CACHE     = 4'ha;
    localparam logic [3:0] SEL_MMU       = 4'hb;

    localparam logic [3:0] PC_REG        = 4'hf;

    // --------------------------------------------------------------
    // status register fields
    // --------------------------------------------------------------
    localparam int STAT_FLAG_HI   = 31;
    localparam int STAT_FLAG_LO   = 28;
    localparam int STAT_RXFULL    = 30;
    localparam int STAT_TXFULL    = 29;
    localparam int STAT_MODE_HI   = 15;
    localparam int STAT_HALT      = 14;
    localparam int STAT_USER_DIS  = 12;
    localparam logic [1:0] MODE_NONE    = 2'h0;
    localparam logic [1:0] MODE_MONITOR = 2'h2;

    // writable status bits: user disable, mode field
    localparam logic [31:0] STATUS_WMASK = 32'h0000_d000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] REG_RESET    = 32'h0000_0000;

    // arbitrary identification value
    localparam logic [31:0] ID_VALUE     = 32'h1234_0001;

    // number of implemented breakpoint and watchpoint pairs
    localparam int NUM_BRK = 6;
    localparam int NUM_WCH = 2;

    // --------------------------------------------------------------
    // instruction kinds
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_MOVE_FROM = 4'b0001,
        OP_MOVE_TO   = 4'b0010,
        OP_LOAD      = 4'b0100,
        OP_STORE     = 4'b1000
    } op_kind_type;

    typedef enum logic [10:0] {
        TGT_NONE     = 11'b000_0000_0001,
        TGT_ID       = 11'b000_0000_0010,
        TGT_STATUS   = 11'b000_0000_0100,
        TGT_TRANSFER = 11'b000_0000_1000,
        TGT_FAULT    = 11'b000_0001_0000,
        TGT_VECTOR   = 11'b000_0010_0000,
        TGT_CACHE    = 11'b000_0100_0000,
        TGT_MMU      = 11'b000_1000_0000,
        TGT_BRK_VAL  = 11'b001_0000_0000,
        TGT_BRK_CTL  = 11'b010_0000_0000,
        TGT_WCH      = 11'b100_0000_0000
    } target_type;

endpackage

// ===== design/debug_reg_decode.sv
// opcode to debug register decode
`timescale 1ns/100ps
module debug_reg_decode (
    input  wire logic [2:0]                      opcode2,
    input  wire logic [3:0]                      regSelect,
    output debug_coproc_pkg::target_type         target,
    output logic                                 implemented
);
    always_comb begin
        target      = debug_coproc_pkg::TGT_NONE;
        implemented = 1'b0;
        unique case (opcode2)
            debug_coproc_pkg::OP2_BASE: begin
                implemented = 1'b1;
                unique case (regSelect)
                    debug_coproc_pkg::SEL_ID:       target = debug_coproc_pkg::TGT_ID;
                    debug_coproc_pkg::SEL_STATUS:   target = debug_coproc_pkg::TGT_STATUS;
                    debug_coproc_pkg::SEL_TRANSFER: target = debug_coproc_pkg::TGT_TRANSFER;
                    debug_coproc_pkg::SEL_FAULT:    target = debug_coproc_pkg::TGT_FAULT;
                    debug_coproc_pkg::SEL_VECTOR:   target = debug_coproc_pkg::TGT_VECTOR;
                    debug_coproc_pkg::SEL_CACHE:    target = debug_coproc_pkg::TGT_CACHE;
                    debug_coproc_pkg::SEL_MMU:      target = debug_coproc_pkg::TGT_MMU;
                    default:                        implemented = 1'b0;
                endcase
            end
            debug_coproc_pkg::OP2_BRK_VALUE: begin
                target      = debug_coproc_pkg::TGT_BRK_VAL;
                implemented = 32'(regSelect) < debug_coproc_pkg::NUM_BRK;
            end
            debug_coproc_pkg::OP2_BRK_CTRL: begin
                target      = debug_coproc_pkg::TGT_BRK_CTL;
                implemented = 32'(regSelect) < debug_coproc_pkg::NUM_BRK;
            end
            debug_coproc_pkg::OP2_WCH_VALUE, debug_coproc_pkg::OP2_WCH_CTRL: begin
                target      = debug_coproc_pkg::TGT_WCH;
                implemented = 32'(regSelect) < debug_coproc_pkg::NUM_WCH;
            end
            default: implemented = 1'b0;
        endcase
    end
endmodule // debug_reg_decode

// ===== design/debug_access_rules.sv
// privilege and debug mode access permission
`timescale 1ns/100ps
module debug_access_rules (
    input  wire logic                            inDebugState,
    input  wire logic                            userMode,
    input  wire logic                            userDisable,
    input  wire logic [1:0]                      debugMode,
    input  wire logic                            isWrite,
    input  debug_coproc_pkg::target_type         target,
    output logic                                 permitted
);
    logic commsTarget;
    logic userAllowed;
    logic privAllowed;

    always_comb begin
        commsTarget = (target == debug_coproc_pkg::TGT_ID && !isWrite) ||
                      (target == debug_coproc_pkg::TGT_STATUS && !isWrite) ||
                      (target == debug_coproc_pkg::TGT_TRANSFER);
        userAllowed = !userDisable && commsTarget;
        privAllowed = commsTarget || target == debug_coproc_pkg::TGT_STATUS ||
                      (!debugMode[0] && debugMode != debug_coproc_pkg::MODE_NONE);
        if (inDebugState) begin
            permitted = 1'b1;
        end else if (userMode) begin
            permitted = userAllowed;
        end else begin
            permitted = privAllowed;
        end
    end
endmodule // debug_access_rules

// ===== design/debug_coproc_access_check.sv
// debug coprocessor decode, access check and register store
`timescale 1ns/100ps
module debug_coproc_access_check (
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    input  wire logic                    power_on_reset_n,
    input  wire logic                    core_reset_n,
    input  wire logic                    debug_port_reset_n,
    input  wire logic                    instValid,
    input  wire logic [3:0]              instKind,
    input  wire logic [2:0]              opcode2,
    input  wire logic [3:0]              coproc_reg_select_field,
    input  wire logic [3:0]              destReg,
    input  wire logic [31:0]             writeData,
    input  wire logic                    inDebugState,
    input  wire logic                    userMode,
    input  wire logic                    receive_full_flag,
    input  wire logic                    transmit_full_flag,
    input  wire logic [31:0]             transfer_receive_side,
    input  wire logic                    resetVectorCatchEn,
    output logic                         undefinedPulse,
    output logic                         accessDone,
    output logic [31:0]                  readData,
    output logic                         flagsWrite,
    output logic [3:0]                   program_status_flags,
    output logic                         receiveRead,
    output logic                         transmitWrite,
    output logic [31:0]                  transfer_transmit_side,
    output logic [31:0]                  debug_status_ctrl_reg,
    output logic [31:0]                  vector_catch_reg,
    output logic [31:0]                  debug_cache_ctrl_reg,
    output logic [31:0]                  debug_mmu_ctrl_reg,
    output logic                         resetCatchTaken
);
    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    debug_coproc_pkg::target_type target;
    logic                         implemented;
    logic                         permitted;
    logic                         isWrite;
    logic                         isRead;
    logic                         memOp;
    logic                         legal;
    logic                         accept;
    logic [31:0]                  readMux;

    debug_reg_decode decodeUnit (
        .opcode2     (opcode2),
        .regSelect   (coproc_reg_select_field),
        .target      (target),
        .implemented (implemented)
    );

    always_comb begin
        isWrite = instKind == debug_coproc_pkg::OP_MOVE_TO || instKind == debug_coproc_pkg::OP_LOAD;
        isRead  = instKind == debug_coproc_pkg::OP_MOVE_FROM || instKind == debug_coproc_pkg::OP_STORE;
        memOp   = instKind == debug_coproc_pkg::OP_LOAD || instKind == debug_coproc_pkg::OP_STORE;
        // loads/stores only legal on transfer register; id is read only
        legal   = implemented && (isWrite || isRead) &&
                  (!memOp || target == debug_coproc_pkg::TGT_TRANSFER) &&
                  !(isWrite && target == debug_coproc_pkg::TGT_ID);
    end

    debug_access_rules accessUnit (
        .inDebugState (inDebugState),
        .userMode     (userMode),
        .userDisable  (debug_status_ctrl_reg[debug_coproc_pkg::STAT_USER_DIS]),
        .debugMode    (debug_status_ctrl_reg[debug_coproc_pkg::STAT_MODE_HI:debug_coproc_pkg::STAT_HALT]),
        .isWrite      (isWrite),
        .target       (target),
        .permitted    (permitted)
    );

    assign accept = instValid && legal && permitted;

    // --------------------------------------------------------------
    // register store, power-on reset domain only
    // --------------------------------------------------------------
    logic [31:0] statusStore_q;
    logic [31:0] faultAddr_q;
    logic [31:0] brkValue_q [debug_coproc_pkg::NUM_BRK];
    logic [31:0] brkCtrl_q  [debug_coproc_pkg::NUM_BRK];
    logic [31:0] wchValue_q [debug_coproc_pkg::NUM_WCH];
    logic [31:0] wchCtrl_q  [debug_coproc_pkg::NUM_WCH];
    logic        regWrite;

    assign regWrite = accept && isWrite;

    // power_on_reset_n is the only clear; rst_b, core and port resets do not touch it
    always_ff @(posedge mclk or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            statusStore_q         <= debug_coproc_pkg::STATUS_RESET;
            faultAddr_q           <= debug_coproc_pkg::REG_RESET;
            vector_catch_reg      <= debug_coproc_pkg::REG_RESET;
            debug_cache_ctrl_reg  <= debug_coproc_pkg::REG_RESET;
            debug_mmu_ctrl_reg    <= debug_coproc_pkg::REG_RESET;
        end else if (regWrite) begin
            unique case (target)
                debug_coproc_pkg::TGT_STATUS: statusStore_q <= writeData & debug_coproc_pkg::STATUS_WMASK;
                debug_coproc_pkg::TGT_FAULT:  faultAddr_q          <= writeData;
                debug_coproc_pkg::TGT_VECTOR: vector_catch_reg     <= writeData;
                debug_coproc_pkg::TGT_CACHE:  debug_cache_ctrl_reg <= writeData;
                debug_coproc_pkg::TGT_MMU:    debug_mmu_ctrl_reg   <= writeData;
                default: ;
            endcase
        end
    end

    for (genvar i = 0; i < debug_coproc_pkg::NUM_BRK; i++) begin : gBrk
        always_ff @(posedge mclk or negedge power_on_reset_n) begin
            if (!power_on_reset_n) begin
                brkValue_q[i] <= debug_coproc_pkg::REG_RESET;
                brkCtrl_q[i]  <= debug_coproc_pkg::REG_RESET;
            end else if (regWrite && 32'(coproc_reg_select_field) == i) begin
                if (target == debug_coproc_pkg::TGT_BRK_VAL) brkValue_q[i] <= writeData;
                if (target == debug_coproc_pkg::TGT_BRK_CTL) brkCtrl_q[i]  <= writeData;
            end
        end
    end

    for (genvar i = 0; i < debug_coproc_pkg::NUM_WCH; i++) begin : gWch
        always_ff @(posedge mclk or negedge power_on_reset_n) begin
            if (!power_on_reset_n) begin
                wchValue_q[i] <= debug_coproc_pkg::REG_RESET;
                wchCtrl_q[i]  <= debug_coproc_pkg::REG_RESET;
            end else if (regWrite && target == debug_coproc_pkg::TGT_WCH &&
                         32'(coproc_reg_select_field) == i) begin
                if (opcode2 == debug_coproc_pkg::OP2_WCH_VALUE) wchValue_q[i] <= writeData;
                else                                            wchCtrl_q[i]  <= writeData;
            end
        end
    end

    // live channel flags sit in bits 30 and 29
    always_comb begin
        debug_status_ctrl_reg = statusStore_q;
        debug_status_ctrl_reg[debug_coproc_pkg::STAT_RXFULL] = receive_full_flag;
        debug_status_ctrl_reg[debug_coproc_pkg::STAT_TXFULL] = transmit_full_flag;
    end

    // --------------------------------------------------------------
    // read path
    // --------------------------------------------------------------
    always_comb begin
        readMux = '0;
        unique case (target)
            debug_coproc_pkg::TGT_ID:       readMux = debug_coproc_pkg::ID_VALUE;
            debug_coproc_pkg::TGT_STATUS:   readMux = debug_status_ctrl_reg;
            debug_coproc_pkg::TGT_TRANSFER: readMux = transfer_receive_side;
            debug_coproc_pkg::TGT_FAULT:    readMux = faultAddr_q;
            debug_coproc_pkg::TGT_VECTOR:   readMux = vector_catch_reg;
            debug_coproc_pkg::TGT_CACHE:    readMux = debug_cache_ctrl_reg;
            debug_coproc_pkg::TGT_MMU:      readMux = debug_mmu_ctrl_reg;
            debug_coproc_pkg::TGT_BRK_VAL:
                if (implemented) readMux = brkValue_q[coproc_reg_select_field[2:0]];
            debug_coproc_pkg::TGT_BRK_CTL:
                if (implemented) readMux = brkCtrl_q[coproc_reg_select_field[2:0]];
            debug_coproc_pkg::TGT_WCH:
                if (implemented) readMux = (opcode2 == debug_coproc_pkg::OP2_WCH_VALUE) ?
                                           wchValue_q[coproc_reg_select_field[0]] :
                                           wchCtrl_q[coproc_reg_select_field[0]];
            debug_coproc_pkg::TGT_NONE:     readMux = '0;
        endcase
    end

    // --------------------------------------------------------------
    // pipeline answer, one cycle after the request
    // --------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            undefinedPulse <= 1'b0;
            accessDone     <= 1'b0;
        end else begin
            undefinedPulse <= instValid && !accept;
            accessDone     <= accept;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            readData             <= '0;
            flagsWrite           <= 1'b0;
            program_status_flags <= '0;
        end else begin
            readData   <= (accept && isRead) ? readMux : '0;
            // pc destination on a move-from updates flags; only status gives defined values
            flagsWrite <= accept && instKind == debug_coproc_pkg::OP_MOVE_FROM &&
                          destReg == debug_coproc_pkg::PC_REG;
            if (target == debug_coproc_pkg::TGT_STATUS)
                program_status_flags <=
                    debug_status_ctrl_reg[debug_coproc_pkg::STAT_FLAG_HI:debug_coproc_pkg::STAT_FLAG_LO];
            else
                program_status_flags <= readMux[debug_coproc_pkg::STAT_FLAG_HI:debug_coproc_pkg::STAT_FLAG_LO];
        end
    end

    // --------------------------------------------------------------
    // transfer register traffic
    // --------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            receiveRead   <= 1'b0;
            transmitWrite <= 1'b0;
        end else begin
            receiveRead   <= accept && isRead && target == debug_coproc_pkg::TGT_TRANSFER;
            transmitWrite <= regWrite && target == debug_coproc_pkg::TGT_TRANSFER;
        end
    end

    always_ff @(posedge mclk or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            transfer_transmit_side <= debug_coproc_pkg::REG_RESET;
        end else if (regWrite && target == debug_coproc_pkg::TGT_TRANSFER) begin
            transfer_transmit_side <= writeData;
        end
    end

    // --------------------------------------------------------------
    // reset vector catch on core reset release
    // --------------------------------------------------------------
    logic coreResetSeen_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            coreResetSeen_q <= 1'b0;
            resetCatchTaken <= 1'b0;
        end else begin
            coreResetSeen_q <= !core_reset_n;
            resetCatchTaken <= coreResetSeen_q && core_reset_n && resetVectorCatchEn;
        end
    end

    logic unusedPortReset;
    assign unusedPortReset = debug_port_reset_n;

endmodule // debug_coproc_access_check

// ===== verif/debug_coproc_access_check_props.sv
// assertions on the debug coprocessor access check ports
`timescale 1ns/100ps
module debug_coproc_access_check_props (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        core_reset_n,
    input wire logic        debug_port_reset_n,
    input wire logic        resetVectorCatchEn,
    input wire logic        instValid,
    input wire logic [3:0]  instKind,
    input wire logic [2:0]  opcode2,
    input wire logic [3:0]  coproc_reg_select_field,
    input wire logic [3:0]  destReg,
    input wire logic [31:0] writeData,
    input wire logic        inDebugState,
    input wire logic        userMode,
    input wire logic        receive_full_flag,
    input wire logic        transmit_full_flag,
    input wire logic        undefinedPulse,
    input wire logic        accessDone,
    input wire logic        flagsWrite,
    input wire logic [3:0]  program_status_flags,
    input wire logic        receiveRead,
    input wire logic        transmitWrite,
    input wire logic [31:0] debug_status_ctrl_reg,
    input wire logic [31:0] vector_catch_reg,
    input wire logic        resetCatchTaken
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic mt;
    logic mf;
    assign mt = instValid && opcode2 == 3'h0 && instKind == debug_coproc_pkg::OP_MOVE_TO;
    assign mf = instValid && opcode2 == 3'h0 && instKind == debug_coproc_pkg::OP_MOVE_FROM;
    property p_answer; instValid |=> accessDone != undefinedPulse; endproperty
    a_answer: assert property (p_answer) else $error("not exactly one answer");
    property p_idle; !instValid |=> !accessDone && !undefinedPulse && !flagsWrite; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_debug; mt && inDebugState && coproc_reg_select_field == 4'h7
        |=> accessDone && vector_catch_reg == $past(writeData); endproperty
    a_debug: assert property (p_debug) else $error("debug state write lost");
    property p_user; mt && !inDebugState && userMode && coproc_reg_select_field == 4'h1 |=> undefinedPulse; endproperty
    a_user: assert property (p_user) else $error("user status write accepted");
    property p_udis; instValid && !inDebugState && userMode && debug_status_ctrl_reg[12] |=> undefinedPulse; endproperty
    a_udis: assert property (p_udis) else $error("user access while disabled");
    property p_flags; mf && coproc_reg_select_field == 4'h1 && destReg == 4'hf && inDebugState
        |=> flagsWrite && program_status_flags[2] == $past(receive_full_flag)
        && program_status_flags[1] == $past(transmit_full_flag); endproperty
    a_flags: assert property (p_flags) else $error("status flags wrong");
    property p_absent; instValid && opcode2 == 3'h4 && coproc_reg_select_field > 4'h5 |=> undefinedPulse; endproperty
    a_absent: assert property (p_absent) else $error("absent breakpoint accepted");
    property p_rx; mf && coproc_reg_select_field == 4'h5 && inDebugState |=> receiveRead && !transmitWrite; endproperty
    a_rx: assert property (p_rx) else $error("transfer read side wrong");
    property p_port; !debug_port_reset_n && !instValid |=> $stable(vector_catch_reg); endproperty
    a_port: assert property (p_port) else $error("port reset changed register");
    property p_catch; $rose(core_reset_n) && resetVectorCatchEn |=> ##[0:1] resetCatchTaken; endproperty
    a_catch: assert property (p_catch) else $error("reset catch missed");
    c_undef: cover property (undefinedPulse);
    c_flags: cover property (flagsWrite);
    c_catch: cover property (resetCatchTaken);
endmodule // debug_coproc_access_check_props

bind debug_coproc_access_check debug_coproc_access_check_props i_props (.*);

// ===== verif/core_side_model.sv
// core side model: receive word and channel full flags
`timescale 1ns/100ps
module core_side_model (
    input  wire logic   mclk,
    input  wire logic   rst_b,
    input  wire logic   receiveRead,
    input  wire logic   transmitWrite,
    output logic [31:0] transfer_receive_side,
    output logic        receive_full_flag,
    output logic        transmit_full_flag
);
    // each pop brings a new word and flips the receive flag; each push flips the transmit flag
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            transfer_receive_side <= 32'h0000_a5a0;
            receive_full_flag <= 1'h1;
            transmit_full_flag <= 1'h0;
        end else begin
            transfer_receive_side <= transfer_receive_side + {31'h0, receiveRead};
            receive_full_flag <= receive_full_flag ^ receiveRead;
            transmit_full_flag <= transmit_full_flag ^ transmitWrite;
        end
    end
endmodule // core_side_model

// ===== verif/debug_coproc_access_check_test.sv
// testbench for the debug coprocessor access check
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module debug_coproc_access_check_test;
    logic        mclk = 0, rst_b = 0, power_on_reset_n = 0, core_reset_n = 0, debug_port_reset_n = 1;
    logic        instValid = 0, inDebugState = 1, userMode = 0, resetVectorCatchEn = 0, dbg = 1, usr = 0;
    logic [3:0]  instKind = 4'h1, coproc_reg_select_field = 4'h0, destReg = 4'h0, dst = 4'h0;
    logic [2:0]  opcode2 = 3'h0;
    logic [31:0] writeData = 32'h0, rx;
    logic        undefinedPulse, accessDone, flagsWrite, receiveRead, transmitWrite, resetCatchTaken;
    logic        receive_full_flag, transmit_full_flag;
    logic [3:0]  program_status_flags;
    logic [31:0] readData, transfer_transmit_side, debug_status_ctrl_reg, vector_catch_reg;
    logic [31:0] debug_cache_ctrl_reg, debug_mmu_ctrl_reg, transfer_receive_side;
    int          num_errors = 0, compares = 0;
    always #2 mclk = ~mclk;
    debug_coproc_access_check i_dut (.*);
    core_side_model i_core (.*);
    // ----------------------------------------------------------
    // one instruction, answer judged in its answer cycle
    // ----------------------------------------------------------
    task automatic op(input logic [3:0] k, input logic [2:0] o2, input logic [3:0] s, input logic [31:0] d,
                      input logic u);
        @(posedge mclk);
        instValid <= 1'h1;
        instKind <= k;
        opcode2 <= o2;
        coproc_reg_select_field <= s;
        writeData <= d;
        destReg <= dst;
        inDebugState <= dbg;
        userMode <= usr;
        @(posedge mclk);
        instValid <= 1'h0;
        #1;
        `CHK("undefined", u, undefinedPulse)
        `CHK("done", ~u, accessDone)
    endtask
    task automatic rd(input logic [3:0] s, input logic u);
        op(debug_coproc_pkg::OP_MOVE_FROM, 3'h0, s, 32'h0, u);
    endtask
    task automatic wr(input logic [3:0] s, input logic [31:0] d, input logic u);
        op(debug_coproc_pkg::OP_MOVE_TO, 3'h0, s, d, u);
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        `CHK("vector", 32'h0, vector_catch_reg)
        wr(4'h7, 32'h0000_0001, 1'h0);
        @(posedge mclk);
        debug_port_reset_n <= 1'h0;
        core_reset_n <= 1'h0;
        resetVectorCatchEn <= 1'h1;
        repeat (4) @(posedge mclk);
        core_reset_n <= 1'h1;
        debug_port_reset_n <= 1'h1;
        for (int i = 0; i < 4 && resetCatchTaken !== 1'h1; i++) begin
            @(posedge mclk);
            #1;
        end
        `CHK("catch", 1'h1, resetCatchTaken)
        `CHK("vector", 32'h1, vector_catch_reg)
        if (resetCatchTaken !== 1'h1) wrap_up();
    endtask
    task automatic t_decode;
        wr(4'ha, 32'h0000_0005, 1'h0);
        `CHK("cache", 32'h5, debug_cache_ctrl_reg)
        wr(4'hb, 32'h0000_0050, 1'h0);
        `CHK("mmu", 32'h50, debug_mmu_ctrl_reg)
        rd(4'h0, 1'h0);
        `CHK("id", debug_coproc_pkg::ID_VALUE, readData)
        op(debug_coproc_pkg::OP_MOVE_TO, 3'h5, 4'h3, 32'h0000_0bc1, 1'h0);
        op(debug_coproc_pkg::OP_MOVE_TO, 3'h7, 4'h1, 32'h0000_0dc1, 1'h0);
        op(debug_coproc_pkg::OP_MOVE_FROM, 3'h5, 4'h3, 32'h0, 1'h0);
        `CHK("brk ctrl", 32'hbc1, readData)
        op(debug_coproc_pkg::OP_MOVE_FROM, 3'h7, 4'h1, 32'h0, 1'h0);
        `CHK("wch ctrl", 32'hdc1, readData)
        op(debug_coproc_pkg::OP_MOVE_FROM, 3'h6, 4'h1, 32'h0, 1'h0);
        `CHK("wch value", 32'h0, readData)
        wr(4'h0, 32'h0, 1'h1);
        op(4'h3, 3'h0, 4'h5, 32'h0, 1'h1);
        op(debug_coproc_pkg::OP_LOAD, 3'h0, 4'h7, 32'h0, 1'h1);
        for (int s = 0; s < 16; s++) rd(s[3:0], !(s inside {0, 1, 5, 6, 7, 10, 11}));
        for (int o = 1; o < 8; o++)
            for (int s = 0; s < 16; s++)
                op(debug_coproc_pkg::OP_MOVE_FROM, o[2:0], s[3:0], 32'h0,
                   o < 4 || s >= (o < 6 ? debug_coproc_pkg::NUM_BRK : debug_coproc_pkg::NUM_WCH));
    endtask
    task automatic t_transfer;
        wr(4'h5, 32'h0000_1234, 1'h0);
        `CHK("tx pulse", 1'h1, transmitWrite)
        `CHK("tx data", 32'h1234, transfer_transmit_side)
        op(debug_coproc_pkg::OP_LOAD, 3'h0, 4'h5, 32'h0000_4321, 1'h0);
        `CHK("tx data", 32'h4321, transfer_transmit_side)
        rx = transfer_receive_side;
        rd(4'h5, 1'h0);
        `CHK("rx pulse", 1'h1, receiveRead)
        `CHK("rx data", rx, readData)
        op(debug_coproc_pkg::OP_STORE, 3'h0, 4'h5, 32'h0, 1'h0);
        `CHK("rx pulse", 1'h1, receiveRead)
        dst = 4'hf;
        rd(4'h1, 1'h0);
        `CHK("flag write", 1'h1, flagsWrite)
        `CHK("flags", {receive_full_flag, transmit_full_flag}, program_status_flags[2:1])
        dst = 4'h0;
    endtask
    task automatic t_perm;
        dbg = 0;
        usr = 1;
        rd(4'h0, 1'h0);
        rd(4'h1, 1'h0);
        wr(4'h5, 32'h0, 1'h0);
        wr(4'h1, 32'h0000_1000, 1'h1);
        wr(4'ha, 32'h0000_0007, 1'h1);
        `CHK("cache", 32'h5, debug_cache_ctrl_reg)
        usr = 0;
        wr(4'ha, 32'h0000_0007, 1'h1);
        wr(4'h1, 32'h0000_4000, 1'h0);
        rd(4'h7, 1'h1);
        wr(4'h1, 32'h0000_c000, 1'h0);
        rd(4'h6, 1'h1);
        wr(4'h1, 32'h0fff_9fff, 1'h0);
        `CHK("status", {receive_full_flag, transmit_full_flag, 29'h9000}, debug_status_ctrl_reg[30:0])
        wr(4'ha, 32'h0000_0007, 1'h0);
        `CHK("cache", 32'h7, debug_cache_ctrl_reg)
        usr = 1;
        rd(4'h0, 1'h1);
        dbg = 1;
        wr(4'h6, 32'h0000_0040, 1'h0);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'h1;
        power_on_reset_n <= 1'h1;
        core_reset_n <= 1'h1;
        t_reset();
        t_decode();
        t_transfer();
        t_perm();
        wrap_up();
    end
endmodule // debug_coproc_access_check_test
